// *** design/bank_cfg_regs.sv ***
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module bank_cfg_regs (
  input  wire logic        pclk,          // controller clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic [31:0]      prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        dll_powered,   // dll powered up, async
  input  wire logic        dll_in_reset,  // dll held in reset, async
  input  wire logic        dll_locked,    // dll locked, async
  output logic             init_start,    // one-cycle init request
  output logic             drive_weak,    // memory drive strength
  output logic             bus_16,        // 16-bit data bus select
  output logic [2:0]       cas_latency,   // cas latency code
  output logic [2:0]       bank_code,     // internal bank code
  output logic [2:0]       page_code,     // page size code
  output logic [31:0]      timing_first,  // first timing word
  output logic [31:0]      timing_second  // second timing word
);
  bank_cfg_pkg::bank_cfg_t  cfg_q;
  bank_cfg_pkg::reg_write_t wr1;
  bank_cfg_pkg::reg_write_t wr2;
  logic        pwr_s;
  logic        rst_s;
  logic        lock_s;
  logic        ready_q;
  logic        access;
  logic        wr_cfg;
  logic        init_q;
  logic        field_chg;
  logic        drive_d;
  logic [31:0] cfg_word;

  assign access = psel && penable;
  assign wr_cfg = access && pwrite && (paddr == bank_cfg_pkg::bank_cfg_addr);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  dll_ready_sync u_pwr (.pclk(pclk), .presetn(presetn),
    .din(dll_powered), .dout(pwr_s));
  dll_ready_sync u_rst (.pclk(pclk), .presetn(presetn),
    .din(dll_in_reset), .dout(rst_s));
  dll_ready_sync u_lck (.pclk(pclk), .presetn(presetn),
    .din(dll_locked), .dout(lock_s));

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ready_q <= 1'b0;
    else
      ready_q <= pwr_s && !rst_s && lock_s;

  // drive bit follows the write only while the stored unlock is set
  assign drive_d = cfg_q.drive_unlock ?
                   pwdata[bank_cfg_pkg::drive_bit] : cfg_q.drive_weak;

  assign field_chg =
    (drive_d != cfg_q.drive_weak) ||
    (pwdata[bank_cfg_pkg::cas_lsb +: 3] != cfg_q.cas_latency) ||
    (pwdata[bank_cfg_pkg::bank_lsb +: 3] != cfg_q.bank_code) ||
    (pwdata[bank_cfg_pkg::page_lsb +: 3] != cfg_q.page_code);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg_q.drive_unlock  <= 1'b0;
      cfg_q.drive_weak    <= 1'b0;
      cfg_q.timing_unlock <= 1'b0;
      cfg_q.bus_16        <= 1'b0;
      cfg_q.cas_latency   <= bank_cfg_pkg::cas_reset;
      cfg_q.bank_code     <= bank_cfg_pkg::bank_reset;
      cfg_q.page_code     <= bank_cfg_pkg::page_reset;
    end
    else if (wr_cfg)
    begin
      cfg_q.drive_unlock  <= pwdata[bank_cfg_pkg::drive_unlock_bit];
      cfg_q.drive_weak    <= drive_d;
      cfg_q.timing_unlock <= pwdata[bank_cfg_pkg::timing_unlock_bit];
      cfg_q.bus_16        <= pwdata[bank_cfg_pkg::bus_width_bit];
      cfg_q.cas_latency   <= pwdata[bank_cfg_pkg::cas_lsb +: 3];
      cfg_q.bank_code     <= pwdata[bank_cfg_pkg::bank_lsb +: 3];
      cfg_q.page_code     <= pwdata[bank_cfg_pkg::page_lsb +: 3];
    end

  // init pulse on a write that updates any of the four fields
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      init_q <= 1'b0;
    else
      init_q <= wr_cfg && field_chg;
  assign init_start = init_q;

  assign drive_weak  = cfg_q.drive_weak;
  assign bus_16      = cfg_q.bus_16;
  assign cas_latency = cfg_q.cas_latency;
  assign bank_code   = cfg_q.bank_code;
  assign page_code   = cfg_q.page_code;

  assign wr1.wr   = access && pwrite && (paddr == bank_cfg_pkg::timing1_addr);
  assign wr1.data = pwdata;
  assign wr2.wr   = access && pwrite && (paddr == bank_cfg_pkg::timing2_addr);
  assign wr2.data = pwdata;

  timing_word_reg u_t1 (.pclk(pclk), .presetn(presetn),
    .unlock(cfg_q.timing_unlock), .wreq(wr1), .value(timing_first));
  timing_word_reg u_t2 (.pclk(pclk), .presetn(presetn),
    .unlock(cfg_q.timing_unlock), .wreq(wr2), .value(timing_second));

  always_comb
  begin
    cfg_word = 32'h0000_0000;
    cfg_word[bank_cfg_pkg::drive_unlock_bit]  = cfg_q.drive_unlock;
    cfg_word[bank_cfg_pkg::res_hi_lsb +: 4]   = bank_cfg_pkg::res_hi_val;
    cfg_word[bank_cfg_pkg::drive_bit]         = cfg_q.drive_weak;
    cfg_word[bank_cfg_pkg::res_mid_lsb +: 2]  = bank_cfg_pkg::res_mid_val;
    cfg_word[bank_cfg_pkg::timing_unlock_bit] = cfg_q.timing_unlock;
    cfg_word[bank_cfg_pkg::bus_width_bit]     = cfg_q.bus_16;
    cfg_word[bank_cfg_pkg::cas_lsb +: 3]      = cfg_q.cas_latency;
    cfg_word[bank_cfg_pkg::bank_lsb +: 3]     = cfg_q.bank_code;
    cfg_word[bank_cfg_pkg::page_lsb +: 3]     = cfg_q.page_code;
  end

  // registered read data, taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      unique case (paddr)
        bank_cfg_pkg::status_addr:
          prdata <= {29'h0, ready_q, 2'h0};
        bank_cfg_pkg::bank_cfg_addr: prdata <= cfg_word;
        bank_cfg_pkg::timing1_addr:  prdata <= timing_first;
        bank_cfg_pkg::timing2_addr:  prdata <= timing_second;
        default:                     prdata <= 32'h0000_0000;
      endcase

  a_ready_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ready_q == $past(pwr_s && !rst_s && lock_s))
    else $error("ready bit does not track dll state");

  a_init_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cfg && field_chg |=> init_start ##1 !init_start)
    else $error("missing one-cycle init pulse");

  a_drive_locked: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_q.drive_unlock |=> $stable(cfg_q.drive_weak))
    else $error("drive strength changed while locked");

  a_drive_unlocked: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cfg && cfg_q.drive_unlock
    |=> drive_weak == $past(pwdata[18]))
    else $error("drive strength write lost");

  a_bus_width: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cfg |=> bus_16 == $past(pwdata[14]))
    else $error("bus width not stored");

  a_cas_field: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cfg |=> cas_latency == $past(pwdata[11:9]))
    else $error("cas latency not stored");

  a_bank_page: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cfg |=> bank_code == $past(pwdata[6:4])
           && page_code == $past(pwdata[2:0]))
    else $error("bank or page code not stored");

  a_timing_gate: assert property (@(posedge pclk) disable iff (!presetn)
    wr1.wr && cfg_q.timing_unlock |=> timing_first == $past(pwdata))
    else $error("unlocked timing write lost");

  a_status_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == bank_cfg_pkg::status_addr
    |=> prdata[31:3] == 29'h0 && prdata[1:0] == 2'h0)
    else $error("status reserved bits not zero");
endmodule

// *** include/bank_cfg_pkg.sv ***
// package: register map, field layout and reset values of the bank config block
package bank_cfg_pkg;
  // register byte addresses
  localparam logic [11:0] status_addr   = 12'h004;
  localparam logic [11:0] bank_cfg_addr = 12'h008;
  localparam logic [11:0] timing1_addr  = 12'h00C;
  localparam logic [11:0] timing2_addr  = 12'h010;
  // status field
  localparam int ready_bit      = 2;
  // bank configuration fields
  localparam int drive_unlock_bit  = 23;
  localparam int res_hi_lsb        = 19;
  localparam int drive_bit         = 18;
  localparam int res_mid_lsb       = 16;
  localparam int timing_unlock_bit = 15;
  localparam int bus_width_bit     = 14;
  localparam int cas_lsb           = 9;
  localparam int bank_lsb          = 4;
  localparam int page_lsb          = 0;
  // reset values
  localparam logic [3:0]  res_hi_val   = 4'h2;
  localparam logic [1:0]  res_mid_val  = 2'h3;
  localparam logic [2:0]  cas_reset    = 3'h3;
  localparam logic [2:0]  bank_reset   = 3'h2;
  localparam logic [2:0]  page_reset   = 3'h2;
  localparam logic [31:0] timing_reset = 32'h0000_0000;

  typedef struct packed {
    logic       drive_unlock;
    logic       drive_weak;
    logic       timing_unlock;
    logic       bus_16;
    logic [2:0] cas_latency;
    logic [2:0] bank_code;
    logic [2:0] page_code;
  } bank_cfg_t;

  typedef struct packed {
    logic        wr;
    logic [31:0] data;
  } reg_write_t;
endpackage

// *** design/dll_ready_sync.sv ***
// three-flop synchroniser with agreement filter for the dll status inputs
`timescale 1ns/100ps
module dll_ready_sync (
  input  wire logic pclk,    // controller clock
  input  wire logic presetn, // async reset, active low
  input  wire logic din,     // asynchronous level
  output logic      dout     // filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end

  // a change counts once the last two stages agree
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dout <= 1'b0;
    else if (s2_q == s3_q)
      dout <= s3_q;
endmodule

// *** design/timing_word_reg.sv ***
// one lockable 32-bit timing register
`timescale 1ns/100ps
module timing_word_reg (
  input  wire logic        pclk,    // controller clock
  input  wire logic        presetn, // async reset, active low
  input  wire logic        unlock,  // write permission
  input  bank_cfg_pkg::reg_write_t wreq, // write strobe and data
  output logic [31:0]      value    // stored word
);
  // a locked write is dropped without any other effect
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      value <= bank_cfg_pkg::timing_reset;
    else if (wreq.wr && unlock)
      value <= wreq.data;

  a_locked_hold: assert property (@(posedge pclk) disable iff (!presetn)
    wreq.wr && !unlock |=> $stable(value))
    else $error("timing word changed while locked");
endmodule

// *** verif/tb.sv ***
// self-checking bench for the bank configuration register block
`timescale 1ns/100ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        dll_powered, dll_in_reset, dll_locked;
  logic        init_start, drive_weak, bus_16;
  logic [2:0]  cas_latency, bank_code, page_code;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, timing_first, timing_second, rd, cfg_m, t1, t2;
  int          bad_count, samples_checked, cyc, inits, seed, i;

  bank_cfg_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dll_powered(dll_powered), .dll_in_reset(dll_in_reset),
    .dll_locked(dll_locked), .init_start(init_start),
    .drive_weak(drive_weak), .bus_16(bus_16), .cas_latency(cas_latency),
    .bank_code(bank_code), .page_code(page_code),
    .timing_first(timing_first), .timing_second(timing_second));

  always #5 pclk = ~pclk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // counts init pulses and cuts a hang short
  always @(posedge pclk)
  begin
    cyc++;
    if (init_start === 1'b1)
      inits++;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t reg got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_port(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t port got %h exp %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk_port({31'h0, pready}, 32'h0000_0001);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // legal word: reserved fields as software must write them
  function automatic logic [31:0] mk(logic ul, logic dr, logic tu, logic b,
                                     logic [2:0] c, logic [2:0] bk,
                                     logic [2:0] pg);
    return {8'h00, ul, 4'h2, dr, 2'h3, tu, b, 2'b00, c, 2'b00, bk, 1'b0, pg};
  endfunction

  task automatic wcfg(input logic [31:0] d);
    logic [31:0] old;
    int n0;
    old = cfg_m;
    n0 = inits;
    cfg_m = {d[31:19], cfg_m[23] ? d[18] : cfg_m[18], d[17:0]};
    apb(1'b1, bank_cfg_pkg::bank_cfg_addr, d);
    repeat (3) @(posedge pclk);
    chk_port(inits - n0, (old[18] != cfg_m[18] || old[11:0] != cfg_m[11:0]));
    apb(1'b0, bank_cfg_pkg::bank_cfg_addr, 32'h0000_0000);
    chk_reg(rd, cfg_m);
    chk_port({drive_weak, bus_16, cas_latency, bank_code, page_code},
             {cfg_m[18], cfg_m[14], cfg_m[11:9], cfg_m[6:4], cfg_m[2:0]});
  endtask

  function automatic logic [31:0] cur(logic ul, logic dr, logic tu);
    return mk(ul, dr, tu, cfg_m[14], cfg_m[11:9], cfg_m[6:4], cfg_m[2:0]);
  endfunction

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {dll_powered, dll_in_reset, dll_locked} = 3'b000;
    seed = 32'h9b38_25be;
    cfg_m = 32'h0013_0622;
    t1 = 32'h0000_0000;
    t2 = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, bank_cfg_pkg::bank_cfg_addr, 32'h0000_0000);
    chk_reg(rd, cfg_m);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0000);
    $display("test reset values done");
    for (i = 0; i < 9; i++)
    begin
      {dll_powered, dll_in_reset, dll_locked} <= (i == 8) ? 3'd5 : i[2:0];
      repeat (8) @(posedge pclk);
      apb(1'b1, bank_cfg_pkg::status_addr, 32'hFFFF_FFFF);
      apb(1'b0, bank_cfg_pkg::status_addr, 32'h0000_0000);
      chk_reg(rd, (i == 5 || i == 8) ? 32'h0000_0004 : 32'h0000_0000);
    end
    $display("test dll status done");
    for (i = 0; i < 10; i++)
      wcfg(mk(1'b0, 1'($random(seed)), 1'b0, 1'($random(seed)),
              3'h2 + 3'($random(seed) & 1), 3'($random(seed) & 3),
              3'($random(seed) & 3)));
    $display("test random config done");
    wcfg(cur(1'b1, 1'b0, 1'b0));
    wcfg(cur(1'b0, 1'b1, 1'b0));
    wcfg(cur(1'b0, 1'b0, 1'b0));
    $display("test drive unlock done");
    for (i = 0; i < 4; i++)
    begin
      if (i == 2)
        wcfg(cur(1'b0, cfg_m[18], 1'b1));
      if (i == 3)
        wcfg(cur(1'b0, cfg_m[18], 1'b0));
      w_timing();
    end
    $display("test timing lock done");
    stop_test();
  end

  task automatic w_timing();
    logic [31:0] a, b;
    int n0;
    a = $random(seed);
    b = $random(seed);
    n0 = inits;
    if (cfg_m[15])
    begin
      t1 = a;
      t2 = b;
    end
    apb(1'b1, bank_cfg_pkg::timing1_addr, a);
    apb(1'b1, bank_cfg_pkg::timing2_addr, b);
    chk_port(timing_first, t1);
    chk_port(timing_second, t2);
    chk_port(inits - n0, 32'h0000_0000);
    apb(1'b0, bank_cfg_pkg::bank_cfg_addr, 32'h0000_0000);
    chk_reg(rd, cfg_m);
  endtask
endmodule
